// file: dclk_consts.vh
// constants for the dynamic clock switch block
// assumes a 40 MHz system clock and an APB register port
`ifndef DCLK_CONSTS_VH
`define DCLK_CONSTS_VH

// register byte addresses
`define ADDR_CMD 12'h000
`define ADDR_SEL 12'h004
`define ADDR_STAT 12'h008
// command register fields
`define CMD_CCE_BIT 7
`define CMD_RDY_BIT 4
`define CMD_REQ_CODE 8'h03
`define CMD_DISABLE 8'h01
`define CMD_ENABLE 8'h02
`define CMD_SWITCH 8'h04
`define CMD_RECOVER 8'h05
`define CMD_WD_ARL 8'h06
// source-selection register fields
`define SEL_SRC_LSB 0
`define SEL_SUT_LSB 4
`define SEL_CLOCK_OUTPUT_ENABLE_BIT 6
`define SRC_MASK 8'h0f
// source codes
`define SRC_RC 4'h2
`define SRC_WD 4'h3
`define SRC_EXT 4'h0
`define SRC_LFX 4'h6
`define SRC_XTAL_MSB 3
// start-up codes
`define SUT_00 2'h0
`define SUT_01 2'h1
`define SUT_10 2'h2
// cycle figures
`define LF_SHORT_CK 20'h00400
`define LF_LONG_CK 20'h08000
`define EXT_WAKE_CK 20'h00006
`define EXT_RESET_CK 20'h0000e
// times in microseconds and the clock rate in MHz
`define T_4MS_US 4100
`define T_65MS_US 65000
`define T_RSTDIS_US 4000
`define CLK_MHZ 40

`endif

// file: dynamic_clock_switch.v
// dynamic clock switch: command decode, source enables, availability counter,
// recovery, clock output and reset start-up delay selection
// assumes an APB master on clk, fuses stable at reset release, sources as single-cycle ticks on clk
`timescale 1ns/1ps
`default_nettype none
`include "dclk_consts.vh"

module dynamic_clock_switch #(
    parameter NSRC = 16,
    parameter CNT_W = 24,
    parameter [CNT_W-1:0] RST_4MS_CK = `T_4MS_US * `CLK_MHZ,
    parameter [CNT_W-1:0] RST_65MS_CK = `T_65MS_US * `CLK_MHZ,
    parameter [CNT_W-1:0] RST_DIS_CK = `T_RSTDIS_US * `CLK_MHZ
) (
    input wire clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [7:0] low_fuse_byte,
    input wire reset_pin_disable_fuse,
    input wire [NSRC-1:0] source_tick,
    input wire sys_clk_div,
    input wire prescaler_active,
    input wire sys_clk_raw,
    input wire timer_wants_lfx,
    input wire timer_wants_ext,
    output reg [NSRC-1:0] source_enable,
    output reg [3:0] system_source,
    output reg switch_pulse,
    output reg wd_auto_reload,
    output reg timer_lfx_grant,
    output reg timer_ext_grant,
    output wire clock_out_pin,
    output wire clock_out_oe,
    output reg [CNT_W-1:0] wake_delay_ck,
    output reg [CNT_W-1:0] reset_delay_ck
);

    reg [7:0] clock_source_select_reg;
    reg command_change_enable_reg;
    reg source_ready_flag_reg;
    reg counting_reg;
    reg [3:0] count_src_reg;
    reg [1:0] count_sut_reg;
    reg [19:0] avail_cnt_reg;
    reg [NSRC-1:0] enable_req_reg;
    reg fuse_load_reg;
    reg [7:0] last_cmd_reg;
    reg [31:0] rdata_reg;

    wire [3:0] source_field = clock_source_select_reg[`SEL_SRC_LSB +: 4];
    wire [1:0] startup_field = clock_source_select_reg[`SEL_SUT_LSB +: 2];
    wire clock_output_enable = clock_source_select_reg[`SEL_CLOCK_OUTPUT_ENABLE_BIT];
    wire wr = psel && penable && pwrite;
    wire rd = psel && !penable && !pwrite;
    wire cmd_wr = wr && (paddr == `ADDR_CMD);
    wire cce_only = (pwdata[7:0] == (8'h01 << `CMD_CCE_BIT));
    wire cmd_go = cmd_wr && command_change_enable_reg && !cce_only;
    wire [7:0] cmd = pwdata[7:0];

    // crystal sources: low crystal code plus the high crystal group
    function is_crystal;
        input [3:0] src;
        begin
            is_crystal = src[`SRC_XTAL_MSB] || (src == `SRC_LFX);
        end
    endfunction

    // availability limit in source ticks for a start-up code
    function [19:0] limit_of;
        input [3:0] src;
        input [1:0] sut;
        begin
            if (src == `SRC_LFX) begin
                limit_of = (sut == `SUT_10) ? `LF_LONG_CK : `LF_SHORT_CK;
            end else begin
                limit_of = `EXT_WAKE_CK;
            end
        end
    endfunction

    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = rdata_reg;

    // register writes, fuse load and command execution
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            clock_source_select_reg <= 8'h00;
            command_change_enable_reg <= 1'b0;
            fuse_load_reg <= 1'b1;
            enable_req_reg <= {NSRC{1'b0}};
            system_source <= `SRC_RC;
            switch_pulse <= 1'b0;
            wd_auto_reload <= 1'b0;
            last_cmd_reg <= 8'h00;
        end else begin
            switch_pulse <= 1'b0;
            fuse_load_reg <= 1'b0;
            if (fuse_load_reg) begin
                // fuses are caught after reset release, never by the async reset
                clock_source_select_reg <= {1'b0, ~low_fuse_byte[`SEL_CLOCK_OUTPUT_ENABLE_BIT],
                    low_fuse_byte[5:0]};
                enable_req_reg[low_fuse_byte[3:0]] <= 1'b1;
                system_source <= low_fuse_byte[3:0];
            end else if (wr && paddr == `ADDR_SEL) begin
                clock_source_select_reg <= pwdata[7:0];
            end
            if (cmd_wr) begin
                // any command write other than the bare change-enable code consumes the change enable; that code sets it
                command_change_enable_reg <= cce_only;
            end
            if (cmd_go) begin
                last_cmd_reg <= cmd;
                case (cmd)
                    `CMD_ENABLE: enable_req_reg[source_field] <= 1'b1;
                    `CMD_DISABLE: begin
                        if (source_field != system_source) begin
                            enable_req_reg[source_field] <= 1'b0;
                        end
                    end
                    `CMD_SWITCH: begin
                        if (source_enable[source_field] && source_ready_flag_reg) begin
                            system_source <= source_field;
                            switch_pulse <= 1'b1;
                        end
                    end
                    `CMD_RECOVER: begin
                        clock_source_select_reg[`SEL_SRC_LSB +: 4] <= system_source;
                    end
                    `CMD_WD_ARL: wd_auto_reload <= 1'b1; // only reset clears it
                    default: ;
                endcase
            end
        end
    end

    // de-glitch: an enable drops only on a source's own tick so it never sees a runt; it rises at once
    integer i;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            source_enable <= {NSRC{1'b0}};
        end else begin
            for (i = 0; i < NSRC; i = i + 1) begin
                if (source_tick[i] || !source_enable[i]) begin
                    source_enable[i] <= enable_req_reg[i];
                end
            end
        end
    end

    // availability counter on ticks of the counted source
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            source_ready_flag_reg <= 1'b0;
            counting_reg <= 1'b0;
            count_src_reg <= 4'h0;
            count_sut_reg <= 2'h0;
            avail_cnt_reg <= 20'h00000;
        end else if (cmd_go && (cmd == `CMD_REQ_CODE || cmd == `CMD_ENABLE)) begin
            source_ready_flag_reg <= 1'b0;
            counting_reg <= 1'b1;
            count_src_reg <= source_field;
            count_sut_reg <= startup_field;
            avail_cnt_reg <= 20'h00000;
        end else if (counting_reg && source_tick[count_src_reg]) begin
            if (avail_cnt_reg + 20'h00001 >= limit_of(count_src_reg, count_sut_reg)) begin
                source_ready_flag_reg <= 1'b1;
                counting_reg <= 1'b0;
            end
            avail_cnt_reg <= avail_cnt_reg + 20'h00001;
        end
    end

    // timer arbitration for the shared low crystal and external input
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            timer_lfx_grant <= 1'b0;
            timer_ext_grant <= 1'b0;
        end else begin
            timer_lfx_grant <= timer_wants_lfx && !(|source_enable[NSRC-1:8]) &&
                !source_enable[`SRC_EXT];
            timer_ext_grant <= timer_wants_ext && !(|source_enable[NSRC-1:8]) &&
                !source_enable[`SRC_LFX];
        end
    end

    // clock output: gated combinationally since it carries the clock itself
    assign clock_out_oe = !rst && clock_output_enable && !is_crystal(system_source);
    assign clock_out_pin = clock_out_oe &&
        (prescaler_active ? sys_clk_div : sys_clk_raw);

    // start-up delays for the selected source and start-up code
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wake_delay_ck <= {CNT_W{1'b0}};
            reset_delay_ck <= {CNT_W{1'b0}};
        end else begin
            wake_delay_ck <= {{(CNT_W-20){1'b0}}, limit_of(source_field, startup_field)};
            reset_delay_ck <= {CNT_W{1'b0}};
            if (source_field == `SRC_LFX) begin
                case (startup_field)
                    `SUT_00: reset_delay_ck <= RST_4MS_CK;
                    `SUT_01: reset_delay_ck <= RST_65MS_CK;
                    `SUT_10: reset_delay_ck <= RST_65MS_CK;
                    default: reset_delay_ck <= {CNT_W{1'b0}};
                endcase
            end else if (source_field == `SRC_EXT) begin
                case (startup_field)
                    `SUT_00: reset_delay_ck <= `EXT_RESET_CK +
                        (reset_pin_disable_fuse ? RST_DIS_CK : {CNT_W{1'b0}});
                    `SUT_01: reset_delay_ck <= `EXT_RESET_CK + RST_4MS_CK;
                    `SUT_10: reset_delay_ck <= `EXT_RESET_CK + RST_65MS_CK;
                    default: reset_delay_ck <= {CNT_W{1'b0}};
                endcase
            end
        end
    end

    // read data registered in the setup cycle
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= 32'h00000000;
        end else if (rd) begin
            case (paddr)
                `ADDR_CMD: rdata_reg <= {24'h000000, command_change_enable_reg, 2'h0,
                    source_ready_flag_reg, 4'h0};
                `ADDR_SEL: rdata_reg <= {24'h000000, clock_source_select_reg};
                `ADDR_STAT: rdata_reg <= {16'h0000, last_cmd_reg, 3'h0, counting_reg,
                    system_source};
                default: rdata_reg <= 32'h00000000;
            endcase
        end
    end

endmodule // dynamic_clock_switch
`default_nettype wire

// file: dclk_props.sv
// port assertions for the dynamic clock switch
// bound onto dynamic_clock_switch from the testbench top file
`timescale 1ns/1ps
`default_nettype none
`include "dclk_consts.vh"
module dclk_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [15:0] source_enable,
    input wire logic [3:0] system_source,
    input wire logic switch_pulse,
    input wire logic wd_auto_reload,
    input wire logic timer_lfx_grant,
    input wire logic timer_ext_grant,
    input wire logic clock_out_pin,
    input wire logic clock_out_oe,
    input wire logic prescaler_active,
    input wire logic sys_clk_div,
    input wire logic sys_clk_raw
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // a running high crystal, or the other of the low crystal and external input, blocks the timer's claim
    wire logic lfx_block = (|source_enable[15:8]) || source_enable[0];
    wire logic ext_block = (|source_enable[15:8]) || source_enable[6];
    wire logic cmd_wr = psel && penable && pwrite && paddr == `ADDR_CMD;
    logic sw_write_reg;
    // remembers a switch code taken at the last edge
    always @(posedge clk or posedge rst) begin
        if (rst)
            sw_write_reg <= 1'b0;
        else
            sw_write_reg <= cmd_wr && pwdata[7:0] == `CMD_SWITCH;
    end
    AST_LFX_GRANT: assert property ((lfx_block ##1 lfx_block) |-> !timer_lfx_grant)
        else $error("low crystal granted to timer while blocked");
    AST_EXT_GRANT: assert property ((ext_block ##1 ext_block) |-> !timer_ext_grant)
        else $error("external input granted to timer while blocked");
    AST_OUT_RESET: assert property (clock_out_oe |-> !$past(rst))
        else $error("clock output driven straight out of reset");
    AST_OUT_MUX: assert property (clock_out_oe |->
        clock_out_pin == (prescaler_active ? sys_clk_div : sys_clk_raw))
        else $error("clock output carries the wrong clock");
    AST_SW_TARGET: assert property (switch_pulse |-> source_enable[system_source])
        else $error("switched to a source that is not enabled");
    AST_SW_ONCE: assert property (switch_pulse |=> !switch_pulse)
        else $error("switch launched twice for one command");
    AST_SW_CAUSE: assert property (switch_pulse |-> sw_write_reg)
        else $error("switch without a switch command");
    AST_WD_HOLD: assert property (wd_auto_reload |=> wd_auto_reload)
        else $error("watchdog reload mode dropped without reset");
endmodule // dclk_props
`default_nettype wire

// file: osc_model.sv
// oscillator bank model: each enabled source ticks once per PERIOD clocks
// assumes source_enable from the clock switch; disabled sources stay silent
`timescale 1ns/1ps
`default_nettype none
module osc_model #(
    parameter int PERIOD = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] source_enable,
    output logic [15:0] source_tick
);
    int cnt;
    // slow ticks so a ready count spans several register polls
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 0;
            source_tick <= 16'h0000;
        end else begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            source_tick <= (cnt == 0) ? source_enable : 16'h0000;
        end
    end
endmodule // osc_model
`default_nettype wire

// file: testbench.sv
// self-checking bench for the clock switch, driven over APB
// assumes osc_model on the far side and dclk_props bound below
`timescale 1ns/1ps
`default_nettype none
`include "dclk_consts.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module testbench;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pres = 0, raw = 0;
    logic wants = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, swp, wdr, lg, eg, cpin, coe;
    logic [15:0] ticks, en;
    logic [3:0] sys;
    logic [23:0] wake, rdel;
    int fail_count = 0, total_checks = 0;
    always #12.5 clk = ~clk;
    always @(posedge clk) raw <= ~raw;
    dynamic_clock_switch #(.RST_4MS_CK(24'h00000a), .RST_65MS_CK(24'h000014),
        .RST_DIS_CK(24'h000005)) dynamic_clock_switch_i (.clk(clk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .low_fuse_byte(8'h46),
        .reset_pin_disable_fuse(1'b0), .source_tick(ticks), .sys_clk_div(~raw),
        .prescaler_active(pres), .sys_clk_raw(raw), .timer_wants_lfx(wants),
        .timer_wants_ext(wants), .source_enable(en), .system_source(sys),
        .switch_pulse(swp), .wd_auto_reload(wdr), .timer_lfx_grant(lg),
        .timer_ext_grant(eg), .clock_out_pin(cpin), .clock_out_oe(coe),
        .wake_delay_ck(wake), .reset_delay_ck(rdel));
    osc_model osc_model_i (.clk(clk), .rst(rst), .source_enable(en), .source_tick(ticks));
    // one apb transfer; starts just after a rising edge, returns at a falling edge
    // one edge after the write lands, so registered outputs are settled for checks
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50) begin @(posedge clk); n++; end
        if (n >= 50) fail_count++;
        r = prdata;
        psel <= 0; penable <= 0;
        @(posedge clk);
        @(negedge clk);
    endtask
    // unlock write first, or the command is dropped; no interrupts here to mask
    task automatic cmd(input logic [7:0] c);
        apb(`ADDR_CMD, 1, 32'h80);
        apb(`ADDR_CMD, 1, {24'h0, c});
    endtask
    // polls the ready flag a bounded number of times
    // stale read data must not count as ready, so the first poll always runs
    task automatic wait_ready;
        int n;
        r = 32'h0;
        for (n = 0; n < 40 && r[`CMD_RDY_BIT] !== 1'b1; n++) apb(`ADDR_CMD, 0, 0);
        `CHK(r[`CMD_RDY_BIT], 1'b1)
    endtask
    task automatic t_fuses;
        `CHK(sys, `SRC_LFX)
        `CHK(wake, 24'h000400)
        apb(`ADDR_SEL, 0, 0);
        `CHK(r[6:0], 7'h06)
    endtask
    // enable, switch, recover, then disable the old source and try the live one, which stays enabled
    task automatic t_switch;
        apb(`ADDR_SEL, 1, 32'h10);
        `CHK(wake, 24'h000006)
        `CHK(rdel, 24'h000018)
        cmd(`CMD_ENABLE);
        `CHK({en[6], en[0]}, 2'b11)
        wait_ready;
        cmd(`CMD_SWITCH);
        `CHK(sys, `SRC_EXT)
        apb(`ADDR_SEL, 1, 32'h16);
        cmd(`CMD_RECOVER);
        apb(`ADDR_SEL, 0, 0);
        `CHK(r[5:0], 6'h10)
        apb(`ADDR_SEL, 1, 32'h06);
        cmd(`CMD_DISABLE);
        apb(`ADDR_SEL, 1, 32'h00);
        cmd(`CMD_DISABLE);
        `CHK({en[6], en[0]}, 2'b01)
    endtask
    task automatic t_refuse_poll;
        apb(`ADDR_SEL, 1, 32'h02);
        apb(`ADDR_CMD, 1, 32'h02);
        `CHK(en[2], 1'b0)
        cmd(`CMD_ENABLE);
        `CHK(en[2], 1'b1)
        wait_ready;
        cmd(`CMD_REQ_CODE);
        apb(`ADDR_CMD, 0, 0);
        `CHK(r[`CMD_RDY_BIT], 1'b0)
        wait_ready;
        cmd(`CMD_WD_ARL);
        `CHK(wdr, 1'b1)
    endtask
    task automatic t_clkout;
        @(posedge clk);
        wants <= 1;
        apb(`ADDR_SEL, 1, 32'h40);
        `CHK(coe, 1'b1)
        `CHK(cpin, raw)
        @(posedge clk);
        pres <= 1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        `CHK(cpin, ~raw)
        `CHK({lg, eg}, 2'b01)
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        `CHK(coe, 1'b0)
        rst <= 0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        t_fuses;
        t_switch;
        t_refuse_poll;
        t_clkout;
        finish_test;
    end
    // cuts a hang short well past the expected run length
    initial begin
        repeat (8000) @(posedge clk);
        fail_count++;
        finish_test;
    end
endmodule // testbench
bind dynamic_clock_switch dclk_props dclk_props_i (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .source_enable(source_enable), .system_source(system_source),
    .switch_pulse(switch_pulse), .wd_auto_reload(wd_auto_reload),
    .timer_lfx_grant(timer_lfx_grant), .timer_ext_grant(timer_ext_grant),
    .clock_out_pin(clock_out_pin), .clock_out_oe(clock_out_oe),
    .prescaler_active(prescaler_active), .sys_clk_div(sys_clk_div), .sys_clk_raw(sys_clk_raw));
`default_nettype wire
